// >>> core/rcps_consts.vh
/*
  Constants for the reset, calibration and power sequencer: register offsets, field
  positions, reset values and cycle counts.
  Assumes inclusion by bare name from the core modules; definitions only.
*/
`ifndef RCPS_CONSTS_VH
`define RCPS_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RCPS_ADDR_W 10
`define RCPS_OFS_CTRL 10'h000
`define RCPS_OFS_STAT 10'h0C0
`define RCPS_OFS_USER 10'h001
`define RCPS_CTRL_SOFT_RESET_BIT 0
`define RCPS_CTRL_STANDBY_BIT 1
`define RCPS_CTRL_SHUTDOWN_BIT 2
`define RCPS_STAT_CAL_DONE_BIT 0
`define RCPS_STAT_ALIGN_MASTER_BIT 1
`define RCPS_CTRL_RESET 8'h01
`define RCPS_USER_RESET 8'h00

// ----------------------------------------------------------------
// Timing in sampling-clock cycles, given as powers of two except the alignment pulse length
// ----------------------------------------------------------------
`define RCPS_CAL_EXP 27
`define RCPS_BGCAL_EXP 30
`define RCPS_POR_EXP 20
`define RCPS_ALIGN_PULSE_CYC 4

`endif

// >>> core/rcps_sequencer.v
/*
  Reset, calibration and power-state sequencer of a multi-channel converter, with
  master/follower alignment over a shared alignment pin and a plain register port.
  Assumes clk_i is the sampling clock, rst_i is power-on reset, and the hardware
  reset, follower-select and alignment pins arrive asynchronously.
*/
// Operation
// [RULE1] After power-on reset, calibrate for 2^27 cycles before results are valid.
// [RULE2] Repeat background calibration every 2^30 cycles without stopping conversion.
// [RULE3] Show calibration status on a pin and a read-only bit at 0xC0.
// [RULE4] Hardware or soft reset recalibration lasts 2^27 cycles, same as power-up.
// [RULE5] During reset: no output, clocks gated, reference power unchanged. A hardware reset clears the shutdown bit, so it turns the reference on.
// [RULE6] Soft reset keeps user registers; hardware reset restores their defaults.
// [RULE7] On hardware reset pin rising edge, load defaults, then recalibrate.
// [RULE8] Soft-reset bit at 0x00 low holds calibration registers at defaults.
// [RULE9] Soft-reset bit going 0 to 1 starts a full calibration.
// [RULE10] Shutdown and standby bits sit in the register at 0x00.
// [RULE11] Shutdown powers down nearly all, reference and clocks too; port stays.
// [RULE12] Standby disables most circuitry but keeps reference, clocks and port.
// [RULE13] Host should issue soft reset while leaving shutdown or standby.
// [RULE14] Host should reset after changing clock rate or configuration.
// [RULE15] Follower-select low: act as alignment master, drive alignment pin.
// [RULE16] Follower-select high: act as follower, alignment pin is an input.
// [RULE17] Alignment starts on power-on reset, hardware reset pin, or soft reset.
// [RULE18] Host discards data until this device reports calibration complete.
// [RULE19] Host trusts aligned output only when all devices report complete.
// [RULE20] After power-on reset wait 2^20 cycles before loading register defaults.
// [RULE21] Calibration-status output is low while calibrating, high when done.
`timescale 1ns/1ns
`include "rcps_consts.vh"
module rcps_sequencer #(
  parameter CAL_CYC = 31'h0800_0000,
  parameter BGCAL_CYC = 31'h4000_0000,
  parameter POR_CYC = 31'h0010_0000,
  parameter ALIGN_PULSE = 31'h0000_0004
) (
  input wire clk_i,
  input wire rst_i,
  input wire hw_reset_n_i,
  input wire follower_sel_i,
  input wire align_in_i,
  output reg align_out_o,
  output reg align_oe_n_o,
  input wire [`RCPS_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  output reg cal_done_o,
  output reg bgcal_active_o,
  output reg conv_out_en_o,
  output reg clk_dist_en_o,
  output reg ref_en_o,
  output reg analog_en_o,
  output reg cal_regs_clear_o,
  output reg [7:0] user_cfg_o
);
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam ST_POR_WAIT = 3'd0;
  localparam ST_ALIGN = 3'd1;
  localparam ST_CAL = 3'd2;
  localparam ST_RUN = 3'd3;
  localparam ST_SOFT_HOLD = 3'd4;
  localparam ST_HW_HOLD = 3'd5;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg hw_n_prev_reg;
  reg soft_prev_reg;
  reg master_reg;
  reg strap_taken_reg;
  reg align_seen_prev_reg;
  reg tmr_start;
  reg bg_start;
  reg [30:0] tmr_load;
  wire hw_n_sync;
  wire follower_sync;
  wire align_sync;
  wire tmr_busy;
  wire tmr_done;
  wire bg_busy;
  wire bg_done;
  wire soft_bit;
  wire stby_bit;
  wire shdn_bit;
  wire hw_rise;
  wire hw_low;
  wire soft_rise;
  wire soft_low;
  wire follower_align_rise;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  rcps_sync3 #(.RESET_VAL(1'b1)) u_sync_hw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(hw_reset_n_i),
    .q_o(hw_n_sync)
  );
  rcps_sync3 #(.RESET_VAL(1'b0)) u_sync_fol (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(follower_sel_i),
    .q_o(follower_sync)
  );
  rcps_sync3 #(.RESET_VAL(1'b0)) u_sync_align (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(align_in_i),
    .q_o(align_sync)
  );

  // ----------------------------------------------------------------
  // Timers: one for waits and calibration, one for background cadence
  // ----------------------------------------------------------------
  rcps_timer #(.W(31)) u_seq_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tmr_start),
    .stop_i(1'b0),
    .load_i(tmr_load),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );
  rcps_timer #(.W(31)) u_bg_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(bg_start),
    .stop_i(state_reg != ST_RUN),
    .load_i(BGCAL_CYC),
    .busy_o(bg_busy),
    .done_o(bg_done)
  );

  assign soft_bit = ctrl_reg[`RCPS_CTRL_SOFT_RESET_BIT];
  assign stby_bit = ctrl_reg[`RCPS_CTRL_STANDBY_BIT];
  assign shdn_bit = ctrl_reg[`RCPS_CTRL_SHUTDOWN_BIT];
  assign hw_rise = hw_n_sync & ~hw_n_prev_reg;
  assign hw_low = ~hw_n_sync;
  assign soft_rise = soft_bit & ~soft_prev_reg;
  assign soft_low = ~soft_bit;
  assign follower_align_rise = align_sync & ~align_seen_prev_reg;

  // ----------------------------------------------------------------
  // Edge history and strap capture
  // ----------------------------------------------------------------
  // The strap is caught once, at the end of the power-on wait. By then the three-stage
  // synchroniser has settled; taken earlier it would still show its reset value.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hw_n_prev_reg <= 1'b1;
      soft_prev_reg <= 1'b1;
      align_seen_prev_reg <= 1'b0;
      master_reg <= 1'b1;
      strap_taken_reg <= 1'b0;
    end else begin
      hw_n_prev_reg <= hw_n_sync;
      soft_prev_reg <= soft_bit;
      align_seen_prev_reg <= align_sync;
      if (!strap_taken_reg && state_reg == ST_POR_WAIT && tmr_done) begin
        master_reg <= ~follower_sync; // RULE15 RULE16
        strap_taken_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // Hardware reset outranks soft reset, which outranks the running sequence.
  always @* begin
    state_next = state_reg;
    tmr_start = 1'b0;
    tmr_load = CAL_CYC;
    bg_start = 1'b0;
    if (hw_low) begin
      state_next = ST_HW_HOLD;
    end else if (hw_rise) begin
      state_next = ST_ALIGN; // RULE7 RULE17
      tmr_start = 1'b1;
      tmr_load = ALIGN_PULSE;
    end else if (soft_low && state_reg != ST_POR_WAIT) begin
      state_next = ST_SOFT_HOLD; // RULE8
    end else if (soft_rise && state_reg != ST_POR_WAIT) begin
      state_next = ST_ALIGN; // RULE9 RULE17
      tmr_start = 1'b1;
      tmr_load = ALIGN_PULSE;
    end else begin
      case (state_reg)
        ST_POR_WAIT: begin
          if (!tmr_busy && !tmr_done && !strap_taken_reg) begin
            tmr_start = 1'b1;
            tmr_load = POR_CYC; // RULE20
          end else if (tmr_done) begin
            state_next = ST_ALIGN; // RULE17
            tmr_start = 1'b1;
            tmr_load = ALIGN_PULSE;
          end
        end
        ST_ALIGN: begin
          // A master leaves after its pulse; a follower waits for the master's.
          if ((master_reg && tmr_done) || (!master_reg && follower_align_rise)) begin
            state_next = ST_CAL;
            tmr_start = 1'b1;
            tmr_load = CAL_CYC; // RULE1 RULE4
          end
        end
        ST_CAL: begin
          if (tmr_done) begin
            state_next = ST_RUN;
            bg_start = 1'b1;
          end
        end
        ST_RUN: begin
          if (bg_done) begin
            bg_start = 1'b1; // RULE2
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_POR_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Hardware reset and the power-on wait restore defaults; soft reset does not.
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_i && addr_i == `RCPS_OFS_CTRL) begin
      ctrl_next = wdata_i;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `RCPS_CTRL_RESET;
      user_cfg_o <= `RCPS_USER_RESET;
      rdata_o <= 8'h00;
    end else begin
      if (state_reg == ST_POR_WAIT || hw_low) begin
        ctrl_reg <= `RCPS_CTRL_RESET; // RULE6 RULE7 RULE20
        user_cfg_o <= `RCPS_USER_RESET;
      end else begin
        ctrl_reg <= ctrl_next; // RULE10
        if (wr_i && addr_i == `RCPS_OFS_USER) begin
          user_cfg_o <= wdata_i; // RULE6
        end
      end
      rdata_o <= 8'h00;
      if (rd_i) begin
        if (addr_i == `RCPS_OFS_CTRL) begin
          rdata_o <= ctrl_reg;
        end else if (addr_i == `RCPS_OFS_USER) begin
          rdata_o <= user_cfg_o;
        end else if (addr_i == `RCPS_OFS_STAT) begin
          rdata_o <= {6'h00, master_reg, cal_done_o}; // RULE3
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs: status, power and clock gating, alignment pin
  // ----------------------------------------------------------------
  // Registered so the pins never glitch on a state change.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_done_o <= 1'b0;
      bgcal_active_o <= 1'b0;
      conv_out_en_o <= 1'b0;
      clk_dist_en_o <= 1'b0;
      ref_en_o <= 1'b1;
      analog_en_o <= 1'b0;
      cal_regs_clear_o <= 1'b1;
      align_out_o <= 1'b0;
      align_oe_n_o <= 1'b1;
    end else begin
      cal_done_o <= (state_next == ST_RUN); // RULE3 RULE21
      bgcal_active_o <= (state_next == ST_RUN) && bg_busy; // RULE2
      conv_out_en_o <= (state_next == ST_RUN) && !shdn_bit && !stby_bit; // RULE5
      clk_dist_en_o <= (state_next == ST_RUN || state_next == ST_CAL) && !shdn_bit; // RULE5 RULE11
      // Reference follows only the shutdown bit; a hardware reset clears that bit and so turns the reference on.
      ref_en_o <= !shdn_bit; // RULE5 RULE11 RULE12
      analog_en_o <= !shdn_bit && !stby_bit; // RULE12
      cal_regs_clear_o <= (state_next == ST_SOFT_HOLD || state_next == ST_HW_HOLD ||
                           state_next == ST_POR_WAIT); // RULE8
      // Until the strap is known the pin stays released, so a follower never drives it.
      align_oe_n_o <= !(master_reg && strap_taken_reg); // RULE15 RULE16
      align_out_o <= master_reg && strap_taken_reg && (state_next == ST_ALIGN); // RULE15
    end
  end
endmodule

// >>> core/rcps_sync3.v
/*
  Three-stage synchroniser for a level from outside the clock domain. The output
  changes only once the second and third stages agree.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
module rcps_sync3 #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output reg q_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // The first stage feeds only the second, to keep metastability contained.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule

// >>> core/rcps_timer.v
/*
  Free-standing cycle timer: loads on start, counts down, pulses done at zero.
  Assumes one clock; the width sets the longest count.
*/
`timescale 1ns/1ns
module rcps_timer #(
  parameter W = 31
) (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire stop_i,
  input wire [W-1:0] load_i,
  output wire busy_o,
  output reg done_o
);
  reg [W-1:0] cnt_reg;
  reg run_reg;

  assign busy_o = run_reg;

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  // Start wins over stop so a restart in the cycle of an abort is kept.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= {W{1'b0}};
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_reg <= load_i;
        run_reg <= 1'b1;
      end else if (stop_i) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
          run_reg <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// >>> verif/rcps_chk.sv
/*
  Checker for the sequencer ports.
  Assumes the bind below and a CAL_CYC equal to the instance's.
*/
`timescale 1ns/1ns
module rcps_chk #(
  parameter CAL_CYC = 31'h0800_0000
) (
  input wire clk_i,
  input wire rst_i,
  input wire hw_reset_n_i,
  input wire [9:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire cal_done_o,
  input wire bgcal_active_o,
  input wire conv_out_en_o,
  input wire clk_dist_en_o,
  input wire ref_en_o,
  input wire analog_en_o,
  input wire cal_regs_clear_o,
  input wire align_out_o,
  input wire align_oe_n_o
);
  reg [31:0] cnt_reg;
  // Counts cycles of a calibration run: clocks on, status still low.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 32'h0000_0000;
    end else if (clk_dist_en_o && !cal_done_o) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end else begin
      cnt_reg <= 32'h0000_0000;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Soft hold is only judged from a running master, so POR-wait writes do not count.
  sequence s_hold;
    wr_i && addr_i == 10'h000 && !wdata_i[0] && cal_done_o && !align_oe_n_o;
  endsequence
  sequence s_run;
    wr_i && addr_i == 10'h000 && wdata_i[0];
  endsequence
  a_cal_length: assert property ($rose(cal_done_o) |->
    $past(cnt_reg) >= CAL_CYC - 2 && $past(cnt_reg) <= CAL_CYC + 2)
    else $error("calibration length wrong");
  a_conv_after_cal: assert property (conv_out_en_o |-> cal_done_o)
    else $error("output before calibration done");
  a_hw_quiet: assert property (!hw_reset_n_i [*6] |->
    !conv_out_en_o && !cal_done_o && cal_regs_clear_o && $stable(ref_en_o))
    else $error("hardware reset state wrong");
  a_stat_read: assert property (rd_i && addr_i == 10'h0C0 |=>
    rdata_o[0] == $past(cal_done_o) && rdata_o[7:2] == 6'h00)
    else $error("status read wrong");
  a_align_pulse: assert property ($rose(align_out_o) |->
    !align_oe_n_o && align_out_o [*4]) else $error("alignment pulse short");
  a_soft_hold: assert property (s_hold |-> ##[1:2] (cal_regs_clear_o && !cal_done_o))
    else $error("soft hold not taken");
  a_soft_start: assert property (s_hold ##1 s_run |-> ##[1:3] align_out_o)
    else $error("soft release did not align");
  a_shut_off: assert property (!ref_en_o |->
    !clk_dist_en_o && !analog_en_o && !conv_out_en_o) else $error("shutdown leak");
  a_standby_off: assert property (ref_en_o && !analog_en_o |-> !conv_out_en_o)
    else $error("standby output on");
  a_bg_run: assert property (bgcal_active_o |-> cal_done_o)
    else $error("background outside run");
endmodule
bind rcps_sequencer rcps_chk #(.CAL_CYC(CAL_CYC)) chk_i (.clk_i, .rst_i, .hw_reset_n_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cal_done_o, .bgcal_active_o, .conv_out_en_o,
  .clk_dist_en_o, .ref_en_o, .analog_en_o, .cal_regs_clear_o, .align_out_o, .align_oe_n_o);

// >>> verif/rcps_peer.sv
/*
  Peer converter strapped as alignment master.
  Assumes go_i is a one-cycle request in the shared clock domain.
*/
`timescale 1ns/1ns
module rcps_peer (
  input wire clk_i,
  input wire go_i,
  output wire sync_o,
  output wire sync_oe_n_o
);
  reg [2:0] cnt_reg = 3'h0;
  // Drives the line high four cycles, then releases it to the pull-down.
  always @(posedge clk_i) begin
    if (go_i) begin
      cnt_reg <= 3'h4;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end
  assign sync_o = cnt_reg != 3'h0;
  assign sync_oe_n_o = cnt_reg == 3'h0;
endmodule

// >>> verif/tb.sv
/*
  Self-checking bench for the sequencer with short counts and a peer master.
  Assumes the checker binds itself.
*/
`timescale 1ns/1ns
`include "rcps_consts.vh"
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hw_n = 1'b1;
  logic fsel = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] u;
  logic [7:0] rdata;
  logic [7:0] ucfg;
  logic done, conv, bg, clk_en, ref_en, ana, clr, aout, aoe_n, p_out, p_oe_n;
  logic [7:0] exp_q[$];
  integer err_total = 0;
  integer total_checks = 0;
  // The shared alignment line has a pull-down, so a released line reads low.
  wire line = !aoe_n ? aout : (!p_oe_n ? p_out : 1'b0);
  always #50 clk_i = ~clk_i;
  rcps_sequencer #(.CAL_CYC(31'h0000_0040), .BGCAL_CYC(31'h0000_00C8),
    .POR_CYC(31'h0000_0010), .ALIGN_PULSE(31'h0000_0004)) uut (.clk_i, .rst_i,
    .hw_reset_n_i(hw_n), .follower_sel_i(fsel), .align_in_i(line), .align_out_o(aout),
    .align_oe_n_o(aoe_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .cal_done_o(done), .bgcal_active_o(bg), .conv_out_en_o(conv),
    .clk_dist_en_o(clk_en), .ref_en_o(ref_en), .analog_en_o(ana),
    .cal_regs_clear_o(clr), .user_cfg_o(ucfg));
  rcps_peer peer (.clk_i, .go_i(go), .sync_o(p_out), .sync_oe_n_o(p_oe_n));
  task chk(input [7:0] seen, input [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One bus cycle; a read notes its expected data for the monitor.
  task bus(input r, input [9:0] a, input [7:0] d);
    wr <= !r;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r) exp_q.push_back(d);
    @(posedge clk_i);
  endtask
  task idle(input integer n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
  task wait_done(input integer n);
    for (int i = 0; i < n && done !== 1'b1; i++) @(posedge clk_i);
    if (done !== 1'b1) begin
      chk(done, 8'h01);
      results();
    end
  endtask
  // Read data stand only in the cycle after the strobe; sample them mid-cycle.
  always @(posedge clk_i) rd_seen <= rd;
  always @(negedge clk_i) if (rd_seen) chk(rdata, exp_q.pop_front());
  initial begin
    void'($urandom(32'he8b8_b2d2));
    u = 8'($urandom) | 8'h01;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(done, 0);
    @(posedge clk_i);
    // A write inside the power-on wait must be lost to the defaults.
    bus(0, `RCPS_OFS_USER, ~u);
    idle(1);
    wait_done(400);
    bus(1, `RCPS_OFS_USER, `RCPS_USER_RESET);
    bus(1, `RCPS_OFS_STAT, 8'h03);
    bus(1, `RCPS_OFS_CTRL, `RCPS_CTRL_RESET);
    bus(1, 10'h3FF, 8'h00);
    bus(0, `RCPS_OFS_USER, u);
    bus(1, `RCPS_OFS_USER, u);
    bus(0, `RCPS_OFS_CTRL, 8'h00);
    idle(2);
    @(negedge clk_i);
    chk({clr, done, conv, ref_en}, 8'h09);
    @(posedge clk_i);
    bus(0, `RCPS_OFS_CTRL, 8'h01);
    idle(1);
    wait_done(200);
    bus(1, `RCPS_OFS_USER, u);
    chk(ucfg, u);
    bus(0, `RCPS_OFS_CTRL, 8'h03);
    idle(3);
    @(negedge clk_i);
    chk({ana, ref_en, clk_en, conv}, 8'h06);
    @(posedge clk_i);
    bus(0, `RCPS_OFS_CTRL, 8'h05);
    bus(1, `RCPS_OFS_CTRL, 8'h05);
    idle(3);
    @(negedge clk_i);
    chk({ana, ref_en, clk_en, conv}, 8'h00);
    @(posedge clk_i);
    bus(0, `RCPS_OFS_CTRL, 8'h00);
    bus(0, `RCPS_OFS_CTRL, 8'h01);
    idle(1);
    wait_done(200);
    idle(3);
    chk({bg, conv, ref_en}, 8'h07);
    // Run past one background wrap: conversion must still be on afterwards.
    repeat (200) @(posedge clk_i);
    @(negedge clk_i);
    chk({bg, conv, ref_en}, 8'h07);
    @(posedge clk_i);
    hw_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({conv, done, ref_en}, 8'h01);
    hw_n <= 1'b1;
    wait_done(300);
    bus(1, `RCPS_OFS_USER, `RCPS_USER_RESET);
    bus(1, `RCPS_OFS_STAT, 8'h03);
    idle(1);
    rst_i <= 1'b1;
    fsel <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk({done, aoe_n}, 8'h01);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    wait_done(200);
    bus(1, `RCPS_OFS_STAT, 8'h01);
    idle(3);
    results();
  end
endmodule
